// ===== sec_pkg.sv
// Package for the serial engine core: modes, formats, reset values and carriers
package sec_pkg;

   typedef enum logic [2:0] {
      SEC_MODE_UART_EXT = 3'h0,
      SEC_MODE_UART_INT = 3'h1,
      SEC_MODE_SPI_SLV = 3'h2,
      SEC_MODE_SPI_MST = 3'h3,
      SEC_MODE_I2C_SLV = 3'h4,
      SEC_MODE_I2C_MST = 3'h5,
      SEC_MODE_RSV6 = 3'h6,
      SEC_MODE_RSV7 = 3'h7
   } sec_mode_t;

   typedef enum logic [1:0] {
      SEC_SMP_16 = 2'h0,
      SEC_SMP_8 = 2'h1,
      SEC_SMP_3 = 2'h2
   } sec_smp_t;

   localparam logic [15:0] SEC_BAUD_RST = 16'h0000;
   localparam logic [2:0] SEC_FRAC_RST = 3'h0;
   localparam int SEC_FRAC_POS = 13;
   localparam int SEC_FRAC_W = 3;
   localparam int SEC_INT_W = 13;
   localparam int SEC_SYNC_W = 8;
   localparam logic [16:0] SEC_ARITH_MOD = 17'h10000;
   localparam logic [3:0] SEC_DIV16_LAST = 4'hF;
   localparam int SEC_RXBUF_DEPTH = 2;
   localparam int SEC_RXBUF_AW = 1;

   // Control carrier from software
   typedef struct packed {
      sec_mode_t mode;
      logic enable;
      logic frac_mode;
      sec_smp_t samples;
      logic [15:0] baud;
      logic dbg_run;
      logic [7:0] match_addr;
      logic [7:0] match_mask;
   } sec_cfg_t;

   // Status carrier to software
   typedef struct packed {
      logic enabled;
      logic halted;
      logic tx_full;
      logic rx_empty;
      logic rx_full;
      logic addr_hit;
   } sec_stat_t;

endpackage

// ===== sec_rxbuf.sv
// Two-entry receive buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sec_rxbuf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_ff [DEPTH];

   initial begin
      if (DEPTH < 2 || WIDTH < 1) begin
         $error("sec_rxbuf: bad size");
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_ff[rd_addr];
      end
   end
endmodule
`default_nettype wire

// ===== sec_core.sv
// Serial engine core: mode select, enable, reset, guard, baud generator, buffers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Three-bit mode picks USART ext/int clock, SPI slave/master, I2C slave/master.
// - Enabled engine serves only the selected mode with all its resources.
// - Enable bit one turns the engine on, zero turns it off.
// - Software reset restores every setting except debug control and disables.
// - Asynchronous transmit uses baud divide-by-samples (16, 8 or 3), receive uses divide-by-1.
// - Synchronous modes use divide-by-2, chosen automatically from the mode.
// - Baud output derives from divisor and the serial engine reference clock.
// - Asynchronous arithmetic divisor is a full sixteen-bit value.
// - Fractional divisor: 13-bit integer, 3-bit fraction; integer at least one.
// - Synchronous modes use only an eight-bit divisor.
// - Guard may lock settings; flag, status, data, match stay writable.
// - Guard lock never blocks writes from an external debugger.
// - Engine runs during debug halt unless debug control asks to halt.
// - Settings cross into the engine clock domain before taking effect.
// - Engine keeps running in sleep while its clock runs; irq wakes.
// - Transmit has one buffer before shifter; receive has two-entry buffer.
// - Address matching acts only in SPI and I2C modes.
// - Bus clock enabled after reset, power manager may gate it.
// - Asynchronous samples per bit selectable as 16, 8 or 3.
// - Shared interrupt high while any enabled flag is set.
module sec_core #(
   parameter int DATA_W = 8,
   parameter int IRQ_W = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cfg_wr,
   input wire logic cfg_wr_dbg,
   input wire sec_pkg::sec_cfg_t cfg_in,
   input wire logic guard_lock,
   input wire logic sw_reset,
   input wire logic cpu_halted,
   input wire logic tx_wr,
   input wire logic [DATA_W-1:0] tx_data,
   output logic tx_load_ff,
   output logic [DATA_W-1:0] tx_shift_ff,
   input wire logic tx_shift_done,
   input wire logic rx_done,
   input wire logic [DATA_W-1:0] rx_shift_data,
   input wire logic rx_rd,
   output logic [DATA_W-1:0] rx_data_ff,
   input wire logic [7:0] rx_addr,
   input wire logic [IRQ_W-1:0] irq_set,
   input wire logic [IRQ_W-1:0] irq_clr,
   input wire logic [IRQ_W-1:0] irq_en,
   output logic irq_ff,
   output logic [IRQ_W-1:0] irq_flag_ff,
   output logic tick_tx_ff,
   output logic tick_rx_ff,
   output logic tick_sync_ff,
   output sec_pkg::sec_cfg_t cfg_ff,
   output sec_pkg::sec_stat_t stat_ff
);
   initial begin
      if (DATA_W < 1 || DATA_W > 16 || IRQ_W < 1) begin
         $error("sec_core: bad width");
      end
   end

   sec_pkg::sec_cfg_t nxt_cfg;
   logic [15:0] div_cnt_ff;
   logic [2:0] frac_acc_ff;
   logic frac_extra_ff;
   logic [3:0] smp_cnt_ff;
   logic [16:0] arith_acc_ff;
   logic sync_half_ff;
   logic tx_full_ff;
   logic [1:0] rx_cnt_ff;
   logic rx_wp_ff;
   logic rx_rp_ff;
   logic [DATA_W-1:0] rx_mem_q;
   logic rx_pend_ff;
   logic active;
   logic is_async;
   logic is_sync;
   logic base_tick;
   logic [3:0] smp_last;
   logic [12:0] frac_int;
   logic [15:0] div_limit;
   logic [2:0] frac_sum;
   logic frac_carry;
   logic addr_hit;

   // Engine halts only when debug control says so
   assign active = cfg_ff.enable && !(cpu_halted && !cfg_ff.dbg_run)
      && (cfg_ff.mode <= sec_pkg::SEC_MODE_I2C_MST);
   assign is_async = (cfg_ff.mode == sec_pkg::SEC_MODE_UART_EXT)
      || (cfg_ff.mode == sec_pkg::SEC_MODE_UART_INT);
   assign is_sync = active && !is_async;

   // Settings sampled on core_clk only; the bus side hands over by strobe
   always_comb begin
      nxt_cfg = cfg_ff;
      if (cfg_wr && (!guard_lock || cfg_wr_dbg)) begin
         nxt_cfg.mode = cfg_in.mode;
         nxt_cfg.enable = cfg_in.enable;
         nxt_cfg.frac_mode = cfg_in.frac_mode;
         nxt_cfg.samples = cfg_in.samples;
         nxt_cfg.baud = cfg_in.baud;
         nxt_cfg.dbg_run = cfg_in.dbg_run;
      end
      if (cfg_wr) begin
         nxt_cfg.match_addr = cfg_in.match_addr;
         nxt_cfg.match_mask = cfg_in.match_mask;
      end
   end

   // One clock from reset on; gating it is the power manager's business
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ff <= '0;
      end else if (sw_reset) begin
         cfg_ff <= '0;
         cfg_ff.dbg_run <= cfg_ff.dbg_run;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Samples per bit
   always_comb begin
      case (cfg_ff.samples)
         sec_pkg::SEC_SMP_8: smp_last = 4'h7;
         sec_pkg::SEC_SMP_3: smp_last = 4'h2;
         default: smp_last = sec_pkg::SEC_DIV16_LAST;
      endcase
   end

   assign frac_int = cfg_ff.baud[sec_pkg::SEC_INT_W-1:0];
   assign {frac_carry, frac_sum} = {1'b0, frac_acc_ff}
      + {1'b0, cfg_ff.baud[sec_pkg::SEC_FRAC_POS +: sec_pkg::SEC_FRAC_W]};

   // Divider reload per format; a fraction carry adds one cycle to each sample period of the next bit
   always_comb begin
      if (is_sync) begin
         div_limit = {8'h00, cfg_ff.baud[sec_pkg::SEC_SYNC_W-1:0]};
      end else if (cfg_ff.frac_mode) begin
         // Integer zero is illegal; treat as one rather than stall
         div_limit = (frac_int == 13'h0000) ? 16'h0000
            : {3'h0, frac_int} - 16'h0001 + {15'h0000, frac_extra_ff};
      end else begin
         div_limit = 16'h0000;
      end
   end

   // Arithmetic mode: phase accumulator, average rate f*(1-BAUD/65536)
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         arith_acc_ff <= '0;
      end else if (!active || sw_reset) begin
         arith_acc_ff <= '0;
      end else if (is_async && !cfg_ff.frac_mode) begin
         arith_acc_ff <= {1'b0, arith_acc_ff[15:0]}
            + (sec_pkg::SEC_ARITH_MOD - {1'b0, cfg_ff.baud});
      end
   end

   // Integer/synchronous divider
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_ff <= '0;
         frac_acc_ff <= sec_pkg::SEC_FRAC_RST;
         frac_extra_ff <= 1'b0;
      end else if (!active || sw_reset) begin
         div_cnt_ff <= '0;
         frac_acc_ff <= sec_pkg::SEC_FRAC_RST;
         frac_extra_ff <= 1'b0;
      end else if (div_cnt_ff >= div_limit) begin
         div_cnt_ff <= '0;
         if (smp_cnt_ff == smp_last && is_async) begin
            frac_acc_ff <= frac_sum;
            frac_extra_ff <= frac_carry;
         end
      end else begin
         div_cnt_ff <= div_cnt_ff + 16'h0001;
      end
   end

   assign base_tick = active && !sw_reset && ((is_async && !cfg_ff.frac_mode)
      ? arith_acc_ff[16] : (div_cnt_ff >= div_limit));

   // Tick outputs: /1 receive, /S transmit, /2 synchronous
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         smp_cnt_ff <= '0;
         sync_half_ff <= 1'b0;
         tick_rx_ff <= 1'b0;
         tick_tx_ff <= 1'b0;
         tick_sync_ff <= 1'b0;
      end else begin
         tick_rx_ff <= base_tick && is_async;
         tick_tx_ff <= base_tick && is_async && (smp_cnt_ff == smp_last);
         tick_sync_ff <= base_tick && is_sync && sync_half_ff;
         if (!active || sw_reset) begin
            smp_cnt_ff <= '0;
            sync_half_ff <= 1'b0;
         end else if (base_tick) begin
            smp_cnt_ff <= (smp_cnt_ff == smp_last) ? 4'h0 : smp_cnt_ff + 4'h1;
            sync_half_ff <= !sync_half_ff;
         end
      end
   end

   // Transmit: one holding buffer in front of the shifter
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_full_ff <= 1'b0;
         tx_load_ff <= 1'b0;
         tx_shift_ff <= '0;
      end else if (sw_reset || !active) begin
         tx_full_ff <= 1'b0;
         if (sw_reset) begin
            tx_shift_ff <= '0;
         end
         tx_load_ff <= 1'b0;
      end else begin
         tx_load_ff <= 1'b0;
         if (tx_full_ff && (tx_shift_done || !tx_load_ff)) begin
            // Hold data until the shifter frees up; extra writes are dropped
            tx_load_ff <= tx_shift_done;
         end
         if (tx_wr && !tx_full_ff) begin
            tx_full_ff <= 1'b1;
            tx_shift_ff <= tx_data;
         end else if (tx_full_ff && tx_shift_done) begin
            tx_full_ff <= 1'b0;
         end
      end
   end

   // Receive: shifter into a two-entry buffer
   sec_rxbuf #(
      .WIDTH(DATA_W),
      .DEPTH(sec_pkg::SEC_RXBUF_DEPTH)
   ) u_rxbuf (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .wr_en(rx_done && active && rx_cnt_ff != 2'h2),
      .wr_addr(rx_wp_ff),
      .wr_data(rx_shift_data),
      .rd_addr(rx_rp_ff),
      .rd_data(rx_mem_q)
   );

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt_ff <= '0;
         rx_wp_ff <= 1'b0;
         rx_rp_ff <= 1'b0;
         rx_pend_ff <= 1'b0;
         rx_data_ff <= '0;
      end else if (sw_reset || !active) begin
         rx_cnt_ff <= '0;
         if (sw_reset) begin
            rx_data_ff <= '0;
         end
         rx_wp_ff <= 1'b0;
         rx_rp_ff <= 1'b0;
         rx_pend_ff <= 1'b0;
      end else begin
         // Overflow beyond two entries drops the newest word
         if (rx_done && rx_cnt_ff != 2'h2) begin
            rx_wp_ff <= !rx_wp_ff;
         end
         rx_pend_ff <= rx_rd && rx_cnt_ff != 2'h0;
         if (rx_pend_ff) begin
            rx_data_ff <= rx_mem_q;
         end
         if (rx_rd && rx_cnt_ff != 2'h0) begin
            rx_rp_ff <= !rx_rp_ff;
         end
         rx_cnt_ff <= rx_cnt_ff + {1'b0, rx_done && rx_cnt_ff != 2'h2}
            - {1'b0, rx_rd && rx_cnt_ff != 2'h0};
      end
   end

   assign addr_hit = ((rx_addr ^ cfg_ff.match_addr) & ~cfg_ff.match_mask) == 8'h00;

   // Sticky flags, set wins over clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_flag_ff <= '0;
         irq_ff <= 1'b0;
      end else if (sw_reset) begin
         irq_flag_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         irq_flag_ff <= (irq_flag_ff & ~irq_clr) | irq_set;
         irq_ff <= |(((irq_flag_ff & ~irq_clr) | irq_set) & irq_en);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_ff <= '0;
      end else begin
         stat_ff.enabled <= cfg_ff.enable && !sw_reset;
         stat_ff.halted <= cpu_halted && !cfg_ff.dbg_run;
         stat_ff.tx_full <= tx_full_ff;
         stat_ff.rx_empty <= rx_cnt_ff == 2'h0;
         stat_ff.rx_full <= rx_cnt_ff == 2'h2;
         stat_ff.addr_hit <= active && !is_async && rx_done && addr_hit;
      end
   end
endmodule
`default_nettype wire

// ===== sec_core_monitor.sv
// Checker for the serial engine core ports
`timescale 1ns/1ps
`default_nettype none
module sec_core_monitor #(
   parameter int IRQ_W = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cfg_wr,
   input wire logic cfg_wr_dbg,
   input wire sec_pkg::sec_cfg_t cfg_in,
   input wire logic guard_lock,
   input wire logic sw_reset,
   input wire logic [IRQ_W-1:0] irq_set,
   input wire logic [IRQ_W-1:0] irq_en,
   input wire logic irq_ff,
   input wire logic [IRQ_W-1:0] irq_flag_ff,
   input wire logic tick_tx_ff,
   input wire logic tick_rx_ff,
   input wire logic tick_sync_ff,
   input wire logic tx_load_ff,
   input wire sec_pkg::sec_cfg_t cfg_ff
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   logic idle;
   logic syn;
   // Two cycles of slack: ticks may trail a settings change
   assign idle = !cfg_ff.enable || cfg_ff.mode > 3'h5;
   assign syn = cfg_ff.mode > 3'h1;
   AST_CFG_APPLY: assert property (cfg_wr && (!guard_lock || cfg_wr_dbg) && !sw_reset
      |=> cfg_ff == $past(cfg_in)) else $error("settings write not applied");
   AST_LOCK_HOLD: assert property (cfg_wr && guard_lock && !cfg_wr_dbg && !sw_reset |=>
      cfg_ff.baud == $past(cfg_ff.baud) && cfg_ff.mode == $past(cfg_ff.mode)
      && cfg_ff.match_addr == $past(cfg_in.match_addr)) else $error("lock misbehaved");
   AST_SWRST: assert property (sw_reset |=> !cfg_ff.enable && cfg_ff.baud == 16'h0000
      && cfg_ff.dbg_run == $past(cfg_ff.dbg_run)) else $error("soft reset wrong");
   AST_IDLE_NO_TICK: assert property ($past(idle) && $past(idle, 2) |->
      !(tick_tx_ff || tick_rx_ff || tick_sync_ff)) else $error("tick while idle");
   AST_SYNC_MODE: assert property (tick_sync_ff |-> $past(syn) || $past(syn, 2))
      else $error("sync tick in async mode");
   AST_ASYNC_MODE: assert property (tick_tx_ff || tick_rx_ff |-> !$past(syn)
      || !$past(syn, 2)) else $error("async tick in sync mode");
   AST_TX_ON_RX: assert property (tick_tx_ff |-> tick_rx_ff)
      else $error("tx tick off rx base");
   AST_SYNC_GAP: assert property (tick_sync_ff |=> !tick_sync_ff)
      else $error("sync ticks adjacent");
   AST_IRQ_LEVEL: assert property (irq_ff == |(irq_flag_ff & $past(irq_en)))
      else $error("irq level wrong");
   AST_FLAG_SET: assert property (|irq_set && !sw_reset |=>
      (irq_flag_ff & $past(irq_set)) == $past(irq_set)) else $error("flag not set");
   cover property (tick_sync_ff);
   cover property (irq_ff);
   cover property (tx_load_ff);
endmodule
bind sec_core sec_core_monitor #(.IRQ_W(IRQ_W)) u_sec_core_monitor (.core_clk(core_clk),
   .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_wr_dbg(cfg_wr_dbg), .cfg_in(cfg_in),
   .guard_lock(guard_lock), .sw_reset(sw_reset), .irq_set(irq_set), .irq_en(irq_en),
   .irq_ff(irq_ff), .irq_flag_ff(irq_flag_ff), .tick_tx_ff(tick_tx_ff),
   .tick_rx_ff(tick_rx_ff), .tick_sync_ff(tick_sync_ff), .tx_load_ff(tx_load_ff),
   .cfg_ff(cfg_ff));
`default_nettype wire

// ===== sec_shifter_model.sv
// Model of the shift registers beyond the engine
`timescale 1ns/1ps
`default_nettype none
module sec_shifter_model (
   input wire logic core_clk,
   input wire logic tx_load_ff,
   input wire logic [7:0] tx_shift_ff,
   output logic tx_shift_done,
   output logic rx_done,
   output logic [7:0] rx_shift_data,
   output logic [7:0] rx_addr
);
   logic [7:0] last_tx = 8'h00;
   initial begin
      tx_shift_done = 1'b0;
      rx_done = 1'b0;
      rx_shift_data = 8'hFF;
      rx_addr = 8'hFF;
   end
   always @(posedge core_clk) if (tx_load_ff) last_tx <= tx_shift_ff;
   task automatic done();
      @(negedge core_clk);
      tx_shift_done = 1'b1;
      @(negedge core_clk);
      tx_shift_done = 1'b0;
   endtask
   // Lines flip after each word so stale data never looks valid
   task automatic rx_word(input logic [7:0] d);
      @(negedge core_clk);
      rx_done = 1'b1;
      rx_shift_data = d;
      rx_addr = d;
      @(negedge core_clk);
      rx_done = 1'b0;
      rx_shift_data = ~d;
      rx_addr = ~d;
   endtask
endmodule
`default_nettype wire

// ===== sec_core_bench.sv
// Self-checking bench for the serial engine core
`timescale 1ns/1ps
`default_nettype none
module sec_core_bench;
   logic core_clk = 0, rst_b = 0, cfg_wr = 0, cfg_wr_dbg = 0, guard_lock = 0, sw_reset = 0;
   logic cpu_halted = 0, tx_wr = 0, rx_rd = 0, tx_load_ff, tx_shift_done, rx_done, irq_ff;
   logic tick_tx_ff, tick_rx_ff, tick_sync_ff;
   logic [7:0] tx_data = 8'h00, tx_shift_ff, rx_shift_data, rx_data_ff, rx_addr;
   logic [3:0] irq_set = 4'h0, irq_clr = 4'h0, irq_en = 4'h0, irq_flag_ff;
   sec_pkg::sec_cfg_t cfg_in = '0, c = '0, e = '0, cfg_ff;
   sec_pkg::sec_stat_t stat_ff;
   int err_count = 0, checks = 0, t, r, s;
   int sn[3] = '{16, 8, 3};
   always #50 core_clk = ~core_clk;
   sec_core u_sec_core (.core_clk(core_clk), .rst_b(rst_b), .cfg_wr(cfg_wr),
      .cfg_wr_dbg(cfg_wr_dbg), .cfg_in(cfg_in), .guard_lock(guard_lock), .sw_reset(sw_reset),
      .cpu_halted(cpu_halted), .tx_wr(tx_wr), .tx_data(tx_data), .tx_load_ff(tx_load_ff),
      .tx_shift_ff(tx_shift_ff), .tx_shift_done(tx_shift_done), .rx_done(rx_done),
      .rx_shift_data(rx_shift_data), .rx_rd(rx_rd), .rx_data_ff(rx_data_ff), .rx_addr(rx_addr),
      .irq_set(irq_set), .irq_clr(irq_clr), .irq_en(irq_en), .irq_ff(irq_ff),
      .irq_flag_ff(irq_flag_ff), .tick_tx_ff(tick_tx_ff), .tick_rx_ff(tick_rx_ff),
      .tick_sync_ff(tick_sync_ff), .cfg_ff(cfg_ff), .stat_ff(stat_ff));
   sec_shifter_model u_sec_shifter_model (.core_clk(core_clk), .tx_load_ff(tx_load_ff),
      .tx_shift_ff(tx_shift_ff), .tx_shift_done(tx_shift_done), .rx_done(rx_done),
      .rx_shift_data(rx_shift_data), .rx_addr(rx_addr));
   task automatic chk(input string n, input logic [63:0] v, input logic [63:0] x);
      checks++;
      if (v !== x) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", n, x, v);
      end
   endtask
   task automatic wr(input logic dbg);
      @(negedge core_clk);
      cfg_in = c;
      cfg_wr = 1;
      cfg_wr_dbg = dbg;
      @(negedge core_clk);
      cfg_wr = 0;
      cfg_wr_dbg = 0;
   endtask
   // 720 cycles holds a whole number of every tick period used
   task automatic cnt();
      t = 0;
      r = 0;
      s = 0;
      repeat (720) @(negedge core_clk) begin
         t += tick_tx_ff;
         r += tick_rx_ff;
         s += tick_sync_ff;
      end
   endtask
   task automatic setm(input logic [2:0] m, input logic f, input logic [1:0] sm,
         input logic [15:0] b);
      c.mode = sec_pkg::sec_mode_t'(m);
      c.enable = 1;
      c.frac_mode = f;
      c.samples = sec_pkg::sec_smp_t'(sm);
      c.baud = b;
      wr(0);
      repeat (100) @(negedge core_clk);
      cnt();
   endtask
   task automatic pulse(ref logic p);
      @(negedge core_clk);
      p = 1;
      @(negedge core_clk);
      p = 0;
      repeat (3) @(negedge core_clk);
   endtask
   task automatic pulse_v(ref logic [3:0] p, input logic [3:0] v);
      @(negedge core_clk);
      p = v;
      @(negedge core_clk);
      p = 4'h0;
      repeat (3) @(negedge core_clk);
   endtask
   task automatic finish_test();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #3ms;
      err_count++;
      finish_test();
   end
   initial begin
      repeat (2) @(negedge core_clk);
      rst_b = 1;
      chk("cfg", cfg_ff, 0);
      for (int m = 2; m < 8; m++) begin
         setm(m, 0, 0, 16'h0304);
         chk("sync", s, m < 6 ? 72 : 0);
         chk("async", t + r, 0);
      end
      for (int i = 0; i < 3; i++) begin
         setm(1, 1, i, 16'h0003);
         chk("rx", r, 240);
         chk("tx", t, 720 / (3 * sn[i]));
      end
      setm(1, 1, 0, 16'h0000);
      chk("rx0", r, 720);
      setm(0, 0, 2, 16'hC000);
      chk("rxa", r, 180);
      chk("txa", t + s, 60);
      setm(3, 0, 0, 16'h0304);
      c.dbg_run = 1;
      wr(0);
      cpu_halted = 1;
      cnt();
      chk("run", s, 72);
      c.dbg_run = 0;
      wr(0);
      cnt();
      chk("halt", s, 0);
      chk("hst", stat_ff.halted, 1);
      cpu_halted = 0;
      c.enable = 0;
      wr(0);
      cnt();
      chk("off", t + r + s, 0);
      guard_lock = 1;
      c.enable = 1;
      c.baud = 16'h1234;
      c.match_addr = 8'h5A;
      wr(0);
      chk("lock", {cfg_ff.enable, cfg_ff.baud, cfg_ff.match_addr}, 25'h003045A);
      wr(1);
      chk("dbg", cfg_ff.baud, 16'h1234);
      guard_lock = 0;
      c.dbg_run = 1;
      wr(0);
      pulse(sw_reset);
      e.dbg_run = 1;
      chk("swr", cfg_ff, e);
      chk("en0", stat_ff.enabled, 0);
      c.mode = sec_pkg::SEC_MODE_UART_INT;
      c.match_mask = 8'h0F;
      wr(0);
      tx_data = 8'hA5;
      pulse(tx_wr);
      chk("tfull", stat_ff.tx_full, 1);
      chk("on", stat_ff.enabled, 1);
      u_sec_shifter_model.done();
      repeat (3) @(negedge core_clk);
      chk("txd", u_sec_shifter_model.last_tx, 8'hA5);
      // Masked address would match here, but the asynchronous modes ignore it
      for (int i = 1; i < 4; i++) begin
         u_sec_shifter_model.rx_word(8'h5A + i);
         chk("nohit", stat_ff.addr_hit, 0);
      end
      repeat (3) @(negedge core_clk);
      chk("rfull", stat_ff.rx_full, 1);
      for (int i = 1; i < 3; i++) begin
         pulse(rx_rd);
         chk("rxd", rx_data_ff, 8'h5A + i);
      end
      chk("remp", stat_ff.rx_empty, 1);
      c.mode = sec_pkg::SEC_MODE_SPI_SLV;
      wr(0);
      u_sec_shifter_model.rx_word(8'h53);
      chk("hit", stat_ff.addr_hit, 1);
      u_sec_shifter_model.rx_word(8'h6A);
      chk("miss", stat_ff.addr_hit, 0);
      irq_en = 4'h2;
      pulse_v(irq_set, 4'h2);
      chk("irq", irq_ff, 1);
      irq_en = 4'h0;
      repeat (2) @(negedge core_clk);
      chk("mask", {irq_ff, irq_flag_ff}, 5'h02);
      pulse_v(irq_clr, 4'h2);
      chk("clr", irq_flag_ff, 0);
      @(negedge core_clk);
      irq_set = 4'h1;
      irq_clr = 4'h1;
      @(negedge core_clk);
      irq_set = 4'h0;
      irq_clr = 4'h0;
      chk("setwin", irq_flag_ff, 4'h1);
      finish_test();
   end
endmodule
`default_nettype wire
